// File: hdl/jlc_consts.vh
`ifndef JLC_CONSTS_VH
`define JLC_CONSTS_VH
// Register addresses (plain port, word index)
`define JLC_ADDR_CTRL1       4'h0
`define JLC_ADDR_CTRL2       4'h1
`define JLC_ADDR_STATUS      4'h2
// Control one field positions
`define JLC_C1_IGNORE        7
`define JLC_C1_CLKSEL        6
`define JLC_C1_RATE_HI       5
`define JLC_C1_RATE_LO       4
`define JLC_C1_IE            1
`define JLC_C1_WCM           0
// Control two field positions
`define JLC_C2_ANALOG_LOOPBACK         7
`define JLC_C2_DIGITAL_LOOPBACK         6
`define JLC_C2_FAST          5
`define JLC_C2_NORMALIZATION_FORMAT          4
`define JLC_C2_TRANSMIT_END_OF_DATA          3
`define JLC_C2_SIFR          2
`define JLC_C2_MIFR_CRC      1
`define JLC_C2_MIFR_NOCRC    0
// Reset values
`define JLC_CTRL1_RST        8'hE0
`define JLC_CTRL2_RST        8'hC0
// Writable masks
`define JLC_CTRL1_WMASK      8'hC3
`define JLC_CTRL2_WMASK      8'hFF
// State vector codes
`define JLC_SV_WAKE          6'h20
`define JLC_SV_BREAK         6'h1C
`define JLC_SV_TXEMPTY       6'h04
`define JLC_SV_NONE          6'h00
// Idle-time counts in link clock ticks (EOF about 280 us, IFS about 300 us)
`define JLC_EOF_US           16'd280
`define JLC_IFS_US           16'd300
// Divider of the 25 MHz clock to the crystal-derived tick
`define JLC_XTAL_DIV_INT     8'd24
`define JLC_XTAL_DIV_BIN     8'd23
// Symbol period in link ticks: normal and 4x
`define JLC_SYM_NORM         8'd96
`define JLC_SYM_FAST         8'd24
`endif

// File: hdl/jlc_link_control.v
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Ignore bit disables receiver, masks interrupts except wake and break, holds status, drops frame.
// - Start-of-frame or break clears ignore bit; requests and status resume.
// - Clock select picks binary or integer link clock; symbol timing follows.
// - Rate field divides crystal clock by 1, 2, 4 or 8.
// - Rate field takes one write after reset, then is read-only.
// - Interrupt enable gates run-mode requests only, not stop or wait exits.
// - Request held until every pending source cleared; disabling may lose it.
// - Wait clock mode set stops internal clocks during CPU wait.
// - Analog loopback returns final-stage input to receiver; bus undriven.
// - After analog loopback clears, wait EOF idle to receive, IFS idle to send.
// - Digital loopback ties digital transmit output to digital receive input.
// - After digital loopback clears, same idle times gate reception and transmission.
// - Fast receive bit gives receive-only 41.6 kbps; clear gives 10.4 kbps both ways.
// - Break clears fast receive bit and loads state vector with break code.
// - Normalization format selects polarity of normalization bit by CRC ending.
// - End-of-data appends CRC after current byte, and after shadow byte if full; crc_append stays low while ifr_type[0] (no-CRC response) is set.
// - Setting end-of-data clears the transmit-empty flag.
// - End-of-data clears at first CRC bit or error; in response, at echoed EOD.
// - Response bits prioritised single over CRC over no-CRC; reads return written pattern.
// - Responder sends active normalization bit before its identifier byte, only once.
// - After losing response arbitration, keep sending identifier until own byte seen.
// - Single-byte response bit clears on success, end-of-data set, or bus error.
module jlc_link_control (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       rx_pin,
    input  wire       tx_bit,
    input  wire       rx_sof,
    input  wire       rx_break,
    input  wire       rx_eod_ok,
    input  wire       tx_first_crc_bit,
    input  wire       tx_byte_done,
    input  wire       tx_shadow_full,
    input  wire       bus_error,
    input  wire       tx_lost_arb,
    input  wire       rx_byte_valid,
    input  wire [7:0] rx_byte,
    input  wire [7:0] own_id,
    input  wire       cpu_wait,
    input  wire       wake_event,
    input  wire       tx_empty_event,
    input  wire       ifr_crc_end,
    output wire       digital_receive_input,
    output reg        bus_tx_out,
    output reg        bus_tx_oe,
    output reg        xcvr_loopback,
    output wire       link_tick,
    output wire       sym_tick,
    output wire       rx_enable,
    output wire       tx_allowed,
    output wire       crc_append,
    output wire       crc_after_shadow,
    output wire       norm_bit_value,
    output reg        send_norm_bit,
    output reg        resend_id,
    output wire [2:0] ifr_type,
    output wire       clocks_run,
    output wire       irq_req
);
`include "jlc_consts.vh"

    localparam ST_RUN   = 2'b00;
    localparam ST_ANALOG_LOOPBACK = 2'b01;
    localparam ST_IDLE  = 2'b10;

    reg [7:0]  ctrl1_q;
    reg [7:0]  ctrl2_q;
    reg        rate_locked_q;
    reg [5:0]  sv_q;
    reg        irq_q;
    reg        norm_sent_q;
    reg [1:0]  st_q;
    reg [15:0] idle_cnt_q;
    reg [7:0]  xdiv_q;
    reg [2:0]  rdiv_q;
    reg [7:0]  sym_q;
    reg        rx_s1_q;
    reg        rx_s2_q;
    reg        rx_prev_q;
    reg        xtick;
    reg        ltick;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; only the second stage is read
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
        end else begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    wire ignore = ctrl1_q[`JLC_C1_IGNORE];
    wire ie     = ctrl1_q[`JLC_C1_IE];
    wire analog_loopback  = ctrl2_q[`JLC_C2_ANALOG_LOOPBACK];
    wire digital_loopback  = ctrl2_q[`JLC_C2_DIGITAL_LOOPBACK];
    wire fast   = ctrl2_q[`JLC_C2_FAST];
    wire transmit_end_of_data   = ctrl2_q[`JLC_C2_TRANSMIT_END_OF_DATA];
    wire [1:0] rate = {ctrl1_q[`JLC_C1_RATE_HI], ctrl1_q[`JLC_C1_RATE_LO]};

    // Digital loopback mux feeding the receiver
    assign digital_receive_input = digital_loopback ? tx_bit : rx_s2_q;

    // Clock gating: only wait mode with the bit set stops the block
    assign clocks_run = ~(cpu_wait & ctrl1_q[`JLC_C1_WCM]);

    ////////////////////////////////////////////////////////////////////////////
    // Crystal tick, then rate divider to the link tick
    wire [7:0] xdiv_max = ctrl1_q[`JLC_C1_CLKSEL] ? `JLC_XTAL_DIV_BIN
                                                  : `JLC_XTAL_DIV_INT;
    wire [2:0] rdiv_max = (rate == 2'b00) ? 3'h0 :
                          (rate == 2'b01) ? 3'h1 :
                          (rate == 2'b10) ? 3'h3 : 3'h7;
    always @* begin
        xtick = clocks_run && (xdiv_q == 8'h00);
        ltick = xtick && (rdiv_q == 3'h0);
    end
    assign link_tick = ltick;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            xdiv_q <= 8'h00;
            rdiv_q <= 3'h0;
            sym_q  <= 8'h00;
        end else if (clocks_run) begin
            xdiv_q <= (xdiv_q == 8'h00) ? (xdiv_max >> 3) : xdiv_q - 8'h01;
            if (xtick)
                rdiv_q <= (rdiv_q == 3'h0) ? rdiv_max : rdiv_q - 3'h1;
            if (ltick)
                sym_q <= (sym_q == 8'h00) ? (fast ? `JLC_SYM_FAST : `JLC_SYM_NORM)
                                          : sym_q - 8'h01;
        end
    end
    // Symbol tick: fast mode runs four times quicker
    assign sym_tick = ltick && (sym_q == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Loopback exit: count idle link ticks before allowing traffic again
    wire rx_edge = (rx_s2_q != rx_prev_q);
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q       <= ST_RUN;
            idle_cnt_q <= 16'h0000;
            rx_prev_q  <= 1'b0;
        end else begin
            rx_prev_q <= rx_s2_q;
            case (st_q)
                ST_RUN: begin
                    if (analog_loopback || digital_loopback)
                        st_q <= ST_ANALOG_LOOPBACK;
                end
                ST_ANALOG_LOOPBACK: begin
                    idle_cnt_q <= 16'h0000;
                    if (!analog_loopback && !digital_loopback)
                        st_q <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (analog_loopback || digital_loopback)
                        st_q <= ST_ANALOG_LOOPBACK;
                    else if (rx_edge)
                        idle_cnt_q <= 16'h0000;
                    else if (ltick && idle_cnt_q != 16'hFFFF)
                        idle_cnt_q <= idle_cnt_q + 16'h0001;
                    if (!rx_edge && idle_cnt_q >= `JLC_IFS_US)
                        st_q <= ST_RUN;
                end
                default: st_q <= ST_RUN;
            endcase
        end
    end
    // Reception needs EOF idle, transmission the longer IFS idle
    wire rx_ok_idle = (st_q == ST_RUN) ||
                      (st_q == ST_IDLE && idle_cnt_q >= `JLC_EOF_US);
    assign rx_enable  = rx_ok_idle && !ignore && (st_q != ST_ANALOG_LOOPBACK || digital_loopback);
    assign tx_allowed = (st_q == ST_RUN) && !fast && !analog_loopback;

    ////////////////////////////////////////////////////////////////////////////
    // Response type priority; raw bits stay readable
    assign ifr_type[2] = ctrl2_q[`JLC_C2_SIFR];
    assign ifr_type[1] = ~ctrl2_q[`JLC_C2_SIFR] & ctrl2_q[`JLC_C2_MIFR_CRC];
    assign ifr_type[0] = ~ctrl2_q[`JLC_C2_SIFR] & ~ctrl2_q[`JLC_C2_MIFR_CRC]
                         & ctrl2_q[`JLC_C2_MIFR_NOCRC];

    assign crc_append       = transmit_end_of_data && !ifr_type[0];
    assign crc_after_shadow = transmit_end_of_data && tx_shadow_full;
    // Format bit 1: CRC ending sends 0; format bit 0 inverts
    assign norm_bit_value = ctrl2_q[`JLC_C2_NORMALIZATION_FORMAT] ^ ifr_crc_end;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; hardware clears win over a same-cycle write
    wire wr1 = reg_wr && (reg_addr == `JLC_ADDR_CTRL1);
    wire wr2 = reg_wr && (reg_addr == `JLC_ADDR_CTRL2);
    reg [7:0] c2_d;
    always @* begin
        c2_d = wr2 ? reg_wdata : ctrl2_q;
        if (rx_break)
            c2_d[`JLC_C2_FAST] = 1'b0;
        if (tx_first_crc_bit || bus_error || (rx_eod_ok && (|ifr_type)))
            c2_d[`JLC_C2_TRANSMIT_END_OF_DATA] = 1'b0;
        if (bus_error || c2_d[`JLC_C2_TRANSMIT_END_OF_DATA] ||
            (ifr_type[2] && tx_byte_done))
            c2_d[`JLC_C2_SIFR] = 1'b0;
        if (bus_error || (tx_lost_arb && !ifr_type[2])) begin
            c2_d[`JLC_C2_MIFR_CRC]   = 1'b0;
            c2_d[`JLC_C2_MIFR_NOCRC] = 1'b0;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl1_q       <= `JLC_CTRL1_RST;
            ctrl2_q       <= `JLC_CTRL2_RST;
            rate_locked_q <= 1'b0;
        end else begin
            ctrl2_q <= c2_d;
            if (wr1) begin
                ctrl1_q <= (ctrl1_q & ~`JLC_CTRL1_WMASK) | (reg_wdata & `JLC_CTRL1_WMASK);
                if (!rate_locked_q) begin
                    ctrl1_q[`JLC_C1_RATE_HI] <= reg_wdata[`JLC_C1_RATE_HI];
                    ctrl1_q[`JLC_C1_RATE_LO] <= reg_wdata[`JLC_C1_RATE_LO];
                end
                rate_locked_q <= 1'b1;
            end
            if (rx_sof || rx_break)
                ctrl1_q[`JLC_C1_IGNORE] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State vector and held request
    // A pending wake stays visible; neither ignore nor a cleared enable drops it
    wire wake_held = (sv_q == `JLC_SV_WAKE);
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sv_q  <= `JLC_SV_NONE;
            irq_q <= 1'b0;
        end else begin
            if (rx_break) begin
                sv_q  <= `JLC_SV_BREAK;
                irq_q <= 1'b1;
            end else if (wake_event) begin
                sv_q  <= `JLC_SV_WAKE;
                irq_q <= 1'b1;
            end else if (ignore && !wake_held) begin
                sv_q  <= `JLC_SV_NONE;
                irq_q <= 1'b0;
            end else if (tx_empty_event && !transmit_end_of_data) begin
                sv_q  <= `JLC_SV_TXEMPTY;
                irq_q <= 1'b1;
            end else if (reg_rd && reg_addr == `JLC_ADDR_STATUS) begin
                sv_q  <= `JLC_SV_NONE;
                irq_q <= 1'b0;
            end else if (wr2 && reg_wdata[`JLC_C2_TRANSMIT_END_OF_DATA] &&
                         sv_q == `JLC_SV_TXEMPTY) begin
                sv_q  <= `JLC_SV_NONE;
                irq_q <= 1'b0;
            end else if (!ie && !wake_held) begin
                irq_q <= 1'b0;
            end
        end
    end
    // Wake requests bypass the enable
    assign irq_req = irq_q && (ie || sv_q == `JLC_SV_WAKE);

    ////////////////////////////////////////////////////////////////////////////
    // Response arbitration: one normalization bit, resend id on loss
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            norm_sent_q   <= 1'b0;
            send_norm_bit <= 1'b0;
            resend_id     <= 1'b0;
        end else begin
            send_norm_bit <= rx_eod_ok && (|ifr_type) && !norm_sent_q;
            if (rx_eod_ok && (|ifr_type))
                norm_sent_q <= 1'b1;
            else if (rx_sof || bus_error)
                norm_sent_q <= 1'b0;
            if (tx_lost_arb && ifr_type[2])
                resend_id <= 1'b1;
            else if ((rx_byte_valid && rx_byte == own_id) || !ifr_type[2])
                resend_id <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus drive: loopback leaves the bus undriven
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_tx_out    <= 1'b0;
            bus_tx_oe     <= 1'b0;
            xcvr_loopback <= 1'b0;
        end else begin
            bus_tx_out    <= tx_bit;
            bus_tx_oe     <= !analog_loopback && !digital_loopback && tx_allowed;
            xcvr_loopback <= analog_loopback;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port; data one cycle after the strobe
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            if (reg_addr == `JLC_ADDR_CTRL1)
                reg_rdata <= ctrl1_q;
            else if (reg_addr == `JLC_ADDR_CTRL2)
                reg_rdata <= ctrl2_q;
            else if (reg_addr == `JLC_ADDR_STATUS)
                reg_rdata <= {2'b00, sv_q};
            else
                reg_rdata <= 8'h00;
        end
    end
endmodule // jlc_link_control

// File: sim/jlc_link_control_chk.sv
`timescale 1ns/1ps
`include "jlc_consts.vh"
module jlc_link_control_chk (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       tx_bit,
    input wire logic       rx_sof,
    input wire logic       rx_break,
    input wire logic       tx_first_crc_bit,
    input wire logic       bus_error,
    input wire logic       cpu_wait,
    input wire logic       ifr_crc_end,
    input wire logic       norm_bit_value,
    input wire logic       digital_receive_input,
    input wire logic       bus_tx_oe,
    input wire logic       xcvr_loopback,
    input wire logic       rx_enable,
    input wire logic       crc_append,
    input wire logic       clocks_run,
    input wire logic [2:0] ifr_type
);
    logic ign_q;
    logic normalization_format_q;
    logic wcm_q;
    wire  wr_c1 = reg_wr && reg_addr == `JLC_ADDR_CTRL1;
    wire  wr_c2 = reg_wr && reg_addr == `JLC_ADDR_CTRL2;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    // Shadow copies of the control bits; hardware clears win over writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ign_q  <= 1'b1;
            normalization_format_q <= 1'b0;
            wcm_q  <= 1'b0;
        end else begin
            ign_q  <= (rx_sof || rx_break) ? 1'b0 : wr_c1 ? reg_wdata[`JLC_C1_IGNORE] : ign_q;
            normalization_format_q <= wr_c2 ? reg_wdata[`JLC_C2_NORMALIZATION_FORMAT] : normalization_format_q;
            wcm_q  <= wr_c1 ? reg_wdata[`JLC_C1_WCM] : wcm_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    ifr_onehot_a: assert property ($onehot0(ifr_type))
        else $error("response type not one-hot");
    digital_loopback_path_a: assert property (wr_c2 && reg_wdata[`JLC_C2_DIGITAL_LOOPBACK] |=>
        digital_receive_input == tx_bit) else $error("loopback path broken");
    analog_loopback_drive_a: assert property (wr_c2 && reg_wdata[`JLC_C2_ANALOG_LOOPBACK] |=>
        ##1 xcvr_loopback && !bus_tx_oe) else $error("bus driven in loopback");
    eod_set_a: assert property (wr_c2 && reg_wdata[`JLC_C2_TRANSMIT_END_OF_DATA] &&
        !tx_first_crc_bit && !bus_error |=> crc_append) else $error("crc not armed");
    eod_clear_a: assert property ((tx_first_crc_bit || bus_error) && !wr_c2
        |=> !crc_append) else $error("end of data not cleared");
    norm_fmt_a: assert property (norm_bit_value == (normalization_format_q ^ ifr_crc_end))
        else $error("normalization bit polarity wrong");
    ignore_rx_a: assert property (ign_q |-> !rx_enable)
        else $error("receiver on while ignoring");
    wait_clk_a: assert property (clocks_run == !(cpu_wait && wcm_q))
        else $error("clock run state wrong");
endmodule // jlc_link_control_chk

// File: sim/jlc_xcvr_model.sv
`timescale 1ns/1ps
// Transceiver stand-in; other nodes show up through ext_level
module jlc_xcvr_model (
    input  wire logic drive_in,
    input  wire logic drive_en,
    input  wire logic loop_en,
    input  wire logic ext_level,
    output wire logic rx_out
);
    wire bus_level;
    // Pull-down bus, wired-or of active drivers; loopback keeps ours off
    assign bus_level = (drive_en && !loop_en && drive_in) || ext_level;
    // Final-stage input returned to the receiver in loopback
    assign rx_out = loop_en ? drive_in : bus_level;
endmodule // jlc_xcvr_model

// File: sim/jlc_link_control_tb_top.sv
`timescale 1ns/1ps
`include "jlc_consts.vh"
module jlc_link_control_tb_top;
    logic       clk, sys_rst, reg_wr, reg_rd, tx_bit, sf, cpu_wait, crc_end, ext;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, ev;
    wire  [7:0] reg_rdata;
    wire  [2:0] ifr_type;
    wire        rx_pin, dri, tx_out, tx_oe, loop, link_tick, rx_enable, tx_allowed;
    wire        crc_append, crc_shd, nbv, clocks_run, irq_req;
    int         n_fail, samples_checked, ticks, cnt[5], i, j, t0, rt;
    ////////////////////////////////////////////////////////////////////////////
    jlc_link_control dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_pin(rx_pin), .tx_bit(tx_bit), .rx_sof(ev[0]), .rx_break(ev[1]),
        .rx_eod_ok(ev[7]), .tx_first_crc_bit(ev[2]), .tx_byte_done(ev[3]),
        .tx_shadow_full(sf), .bus_error(ev[4]), .tx_lost_arb(1'b0), .rx_byte_valid(1'b0),
        .rx_byte(8'h00), .own_id(8'h00), .cpu_wait(cpu_wait), .wake_event(ev[5]),
        .tx_empty_event(ev[6]), .ifr_crc_end(crc_end), .digital_receive_input(dri),
        .bus_tx_out(tx_out), .bus_tx_oe(tx_oe), .xcvr_loopback(loop),
        .link_tick(link_tick), .sym_tick(), .rx_enable(rx_enable), .tx_allowed(tx_allowed),
        .crc_append(crc_append), .crc_after_shadow(crc_shd), .norm_bit_value(nbv),
        .send_norm_bit(), .resend_id(), .ifr_type(ifr_type), .clocks_run(clocks_run),
        .irq_req(irq_req));
    jlc_xcvr_model xcvr_u (.drive_in(tx_out), .drive_en(tx_oe), .loop_en(loop),
        .ext_level(ext), .rx_out(rx_pin));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, link tick counter, watchdog at 75k cycles, past the expected 50k
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (link_tick) ticks <= ticks + 1;
    initial begin
        #3000000;
        n_fail++;
        print_verdict;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask
    task automatic pulse(input int n);
        @(posedge clk);
        ev <= 8'h01 << n;
        @(posedge clk);
        ev <= 8'h00;
        repeat (2) @(negedge clk);
    endtask
    task automatic do_rst;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
    endtask
    function automatic logic [7:0] near(input int a, input int b, input int tol);
        return {7'b0, (a - b <= tol) && (b - a <= tol)};
    endfunction
    task automatic print_verdict;
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {reg_wr, reg_rd, tx_bit, sf, cpu_wait, crc_end, ext} = '0;
        {reg_addr, reg_wdata, ev} = '0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values, status, an unmapped address
        rd(`JLC_ADDR_CTRL1, `JLC_CTRL1_RST);
        rd(`JLC_ADDR_CTRL2, `JLC_CTRL2_RST);
        rd(`JLC_ADDR_STATUS, 8'h00);
        rd(4'hF, 8'h00);
        // Each rate code after a fresh reset; last pass picks the binary clock
        for (i = 0; i < 5; i++) begin
            do_rst;
            wr(`JLC_ADDR_CTRL1, {1'b0, i == 4, i[1:0], 4'h0});
            wr(`JLC_ADDR_CTRL1, {1'b0, i == 4, ~i[1:0], 4'h0});
            rd(`JLC_ADDR_CTRL1, {1'b0, i == 4, i[1:0], 4'h0});
            t0 = ticks;
            repeat (9600) @(posedge clk);
            cnt[i] = ticks - t0;
        end
        for (i = 1; i < 4; i++) chk(near(cnt[i] << i, cnt[0], 9), 8'h01);
        chk({7'b0, cnt[4] > cnt[0] + 9}, 8'h01);
        // Requests masked while ignoring, then held until status is read
        do_rst;
        wr(`JLC_ADDR_CTRL1, 8'h82);
        pulse(6);
        chk({7'b0, irq_req}, 8'h00);
        pulse(0);
        rd(`JLC_ADDR_CTRL1, 8'h02);
        pulse(6);
        chk({7'b0, irq_req}, 8'h01);
        rd(`JLC_ADDR_STATUS, {2'b0, `JLC_SV_TXEMPTY});
        chk({7'b0, irq_req}, 8'h00);
        pulse(6);
        wr(`JLC_ADDR_CTRL2, 8'h08);
        rd(`JLC_ADDR_STATUS, 8'h00);
        pulse(2);
        rd(`JLC_ADDR_CTRL2, 8'h00);
        // Wake request passes both the ignore mask and a cleared enable
        wr(`JLC_ADDR_CTRL1, 8'h80);
        pulse(5);
        chk({7'b0, irq_req}, 8'h01);
        rd(`JLC_ADDR_STATUS, {2'b0, `JLC_SV_WAKE});
        wr(`JLC_ADDR_CTRL2, 8'h20);
        pulse(1);
        rd(`JLC_ADDR_CTRL2, 8'h00);
        rd(`JLC_ADDR_CTRL1, 8'h00);
        rd(`JLC_ADDR_STATUS, {2'b0, `JLC_SV_BREAK});
        // Every non-zero response pattern, illegal multi-bit ones too
        for (i = 1; i < 8; i++) begin
            wr(`JLC_ADDR_CTRL2, 8'(i));
            rd(`JLC_ADDR_CTRL2, 8'(i));
            chk({5'b0, ifr_type}, i[2] ? 8'h04 : i[1] ? 8'h02 : 8'h01);
        end
        for (i = 0; i < 2; i++) begin
            wr(`JLC_ADDR_CTRL2, i ? 8'h0C : 8'h04);
            pulse(i ? 4 : 3);
            rd(`JLC_ADDR_CTRL2, 8'h00);
        end
        @(posedge clk) sf <= 1'b1;
        wr(`JLC_ADDR_CTRL2, 8'h08);
        @(negedge clk);
        chk({6'b0, crc_append, crc_shd}, 8'h03);
        pulse(4);
        for (i = 0; i < 4; i++) begin
            wr(`JLC_ADDR_CTRL2, {3'b0, i[1], 4'h0});
            crc_end <= i[0];
            @(negedge clk);
            chk({7'b0, nbv}, {7'b0, i[1] ^ i[0]});
        end
        // Loopbacks, then idle times before reception and transmission
        wr(`JLC_ADDR_CTRL2, 8'h40);
        for (i = 0; i < 2; i++) begin
            tx_bit <= i[0];
            @(negedge clk);
            chk({7'b0, dri}, {7'b0, i[0]});
            @(posedge clk);
        end
        wr(`JLC_ADDR_CTRL2, 8'h80);
        repeat (2) @(negedge clk);
        chk({6'b0, loop, tx_oe}, 8'h02);
        wr(`JLC_ADDR_CTRL2, 8'h00);
        t0 = ticks;
        rt = 0;
        for (j = 0; j < 20000 && !tx_allowed; j++) begin
            @(posedge clk);
            if (rx_enable && rt == 0) rt = ticks - t0;
        end
        chk(near(rt, 280, 3), 8'h01);
        chk(near(ticks - t0, 300, 3), 8'h01);
        @(posedge clk) ext <= 1'b1;
        repeat (3) @(negedge clk);
        chk({7'b0, dri}, 8'h01);
        wr(`JLC_ADDR_CTRL1, 8'h01);
        cpu_wait <= 1'b1;
        @(negedge clk);
        chk({7'b0, clocks_run}, 8'h00);
        print_verdict;
    end
endmodule // jlc_link_control_tb_top

bind jlc_link_control jlc_link_control_chk chk_u (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .tx_bit(tx_bit),
    .rx_sof(rx_sof), .rx_break(rx_break), .tx_first_crc_bit(tx_first_crc_bit),
    .bus_error(bus_error), .cpu_wait(cpu_wait), .ifr_crc_end(ifr_crc_end),
    .norm_bit_value(norm_bit_value),
    .digital_receive_input(digital_receive_input), .bus_tx_oe(bus_tx_oe),
    .xcvr_loopback(xcvr_loopback), .rx_enable(rx_enable), .crc_append(crc_append),
    .clocks_run(clocks_run), .ifr_type(ifr_type));
